// File: hw/atx_tx_dma.sv
// Transmit segmentation DMA: descriptor fetch, cell build, AAL5 tail.
// Assumes a host memory master port and a scheduler on core_clk.
`default_nettype none
module atx_tx_dma
	import atx_pkg::*;
#(
	parameter int unsigned CM_AW    = ATX_CM_AW,
	parameter int unsigned CM_DEPTH = ATX_GROUPS * ATX_WORDS
) (
	input  wire logic             core_clk,
	input  wire logic             rst_b,
	input  wire logic             opp_valid,
	output logic                  opp_ready,
	input  wire logic [7:0]       opp_group,
	input  wire logic             cm_req,
	input  wire logic             cm_we,
	input  wire logic [CM_AW-1:0] cm_addr,
	input  wire logic [31:0]      cm_wdata,
	output logic                  cm_rvalid,
	output logic [31:0]           cm_rdata,
	output logic                  hm_req,
	output logic                  hm_we,
	output logic [31:0]           hm_addr,
	output logic [31:0]           hm_wdata,
	input  wire logic             hm_gnt,
	input  wire logic             hm_rvalid,
	input  wire logic [31:0]      hm_rdata,
	output logic                  cell_valid,
	input  wire logic             cell_ready,
	output logic [7:0]            cell_data,
	output logic                  cell_sop,
	output logic                  cell_idle,
	output logic                  cmpl_valid,
	output logic [7:0]            cmpl_group,
	output logic                  cmpl_irq
);
	if (CM_AW < 11 || CM_DEPTH < ATX_GROUPS * ATX_WORDS || CM_DEPTH > (1 << CM_AW)) begin : g_chk
		$error("Control memory too small for all groups");
	end
	atx_cm_if #(.AW(CM_AW)) host_cm ();
	atx_cm_if #(.AW(CM_AW)) eng_cm ();
	atx_cmem #(
		.AW   (CM_AW),
		.DEPTH(CM_DEPTH)
	) u_cmem (
		.core_clk(core_clk),
		.rst_b   (rst_b),
		.a       (host_cm),
		.b       (eng_cm)
	);
	atx_state_t  st_q;
	logic [31:0] w_q [ATX_WORDS];
	logic [31:0] dsc_q [4];
	logic [7:0]  pend_grp_q;
	logic [7:0]  grp_q;
	logic        opp_rdy_q;
	logic [2:0]  k_q;
	logic [5:0]  pos_q;
	logic        idle_q;
	logic        mid_q;
	logic        done_buf_q;
	logic        cell_done_q;
	logic [31:0] prev_desc_q;
	logic [7:0]  byte_q;
	logic        sop_q;
	logic        ecm_req_q;
	logic        ecm_we_q;
	logic [2:0]  ecm_word_q;
	logic [31:0] ecm_wdata_q;
	logic        hm_req_q;
	logic        hm_we_q;
	logic [31:0] hm_addr_q;
	logic [31:0] hm_wdata_q;
	logic        cmpl_v_q;
	logic [7:0]  cmpl_grp_q;
	logic        cmpl_irq_q;
	logic [9:0]  out_q;
	logic        out_v_q;
	logic [9:0]  skid_q;
	logic        skid_v_q;
	logic        buf_rdy;
	logic        push;
	logic [31:0] state_w;
	logic [31:0] ptr_w;
	logic [31:0] hdr_w;
	logic [31:0] ring_w;
	logic [31:0] crc_w;
	logic [31:0] tail_w;
	logic        last_cell;
	logic        aal5;
	logic [31:0] hdr_word;
	logic [7:0]  pad_byte;
	logic [7:0]  lane_byte;
	logic        pad_in_crc;
	atx_state_t  ret_st;
	assign host_cm.req = cm_req;
	assign host_cm.we = cm_we;
	assign host_cm.addr = cm_addr;
	assign host_cm.wdata = cm_wdata;
	assign cm_rdata = host_cm.rdata;
	assign cm_rvalid = host_cm.rvalid;
	assign eng_cm.req = ecm_req_q;
	assign eng_cm.we = ecm_we_q;
	assign eng_cm.addr = CM_AW'({grp_q, ecm_word_q});
	assign eng_cm.wdata = ecm_wdata_q;
	assign state_w = w_q[TX_DMA_STATE_WORD];
	assign ptr_w = w_q[TX_DMA_CURRENT_POINTER];
	assign hdr_w = w_q[TX_DMA_CELL_HEADER];
	assign ring_w = w_q[TX_DMA_RING_POINTER];
	assign crc_w = w_q[TX_DMA_PARTIAL_CRC];
	assign tail_w = w_q[TX_DMA_TRAILER_FIELDS];
	assign last_cell = (state_w[26:16] == PKT_LAST_CELL);
	assign aal5 = !state_w[BIT_ADAPTATION_TYPE];
	assign hdr_word = idle_q ? IDLE_HEADER :
		{4'h0, hdr_w[27:4], last_cell ? hdr_w[31:28] : hdr_w[3:0]};
	assign lane_byte = hm_rdata[{ptr_w[1:0], 3'b111} -: 8];
	assign pad_byte = !(aal5 && last_cell) ? 8'h00 :
		(pos_q >= CRC_POS) ? ~crc_w[{~pos_q[1:0], 3'b111} -: 8] :
		(pos_q >= TAIL_POS) ? tail_w[{~pos_q[1:0], 3'b111} -: 8] : 8'h00;
	assign pad_in_crc = aal5 && !(last_cell && pos_q >= CRC_POS);
	assign ret_st = cell_done_q ? S_END : S_CELL;
	assign buf_rdy = !skid_v_q;
	assign push = (st_q == S_EMIT) && buf_rdy;
	// Opportunity holding register
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			opp_rdy_q <= 1'b1;
			pend_grp_q <= 8'h00;
		end else if (opp_valid && opp_rdy_q) begin
			opp_rdy_q <= 1'b0;
			pend_grp_q <= opp_group;
		end else if (st_q == S_WAIT && !opp_rdy_q) begin
			opp_rdy_q <= 1'b1;
		end
	end
	// Segmentation engine
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st_q <= S_WAIT;
			for (int i = 0; i < ATX_WORDS; i++) w_q[i] <= WORD_RESET;
			for (int i = 0; i < 4; i++) dsc_q[i] <= WORD_RESET;
			grp_q <= 8'h00;
			k_q <= 3'h0;
			pos_q <= 6'h00;
			idle_q <= 1'b0;
			mid_q <= 1'b0;
			done_buf_q <= 1'b0;
			cell_done_q <= 1'b0;
			prev_desc_q <= WORD_RESET;
			byte_q <= 8'h00;
			sop_q <= 1'b0;
			ecm_req_q <= 1'b0;
			ecm_we_q <= 1'b0;
			ecm_word_q <= 3'h0;
			ecm_wdata_q <= WORD_RESET;
			hm_req_q <= 1'b0;
			hm_we_q <= 1'b0;
			hm_addr_q <= WORD_RESET;
			hm_wdata_q <= WORD_RESET;
			cmpl_v_q <= 1'b0;
			cmpl_grp_q <= 8'h00;
			cmpl_irq_q <= 1'b0;
		end else begin
			ecm_req_q <= 1'b0;
			cmpl_v_q <= 1'b0;
			cmpl_irq_q <= 1'b0;
			if (hm_req_q && hm_gnt)
				hm_req_q <= 1'b0;
			unique case (st_q)
				S_WAIT: begin
					if (!opp_rdy_q) begin
						grp_q <= pend_grp_q;
						k_q <= 3'h0;
						st_q <= S_RD;
					end
				end
				S_RD: begin
					ecm_req_q <= 1'b1;
					ecm_we_q <= 1'b0;
					ecm_word_q <= rd_word(k_q);
					st_q <= S_RDW;
				end
				S_RDW: begin
					if (eng_cm.rvalid) begin
						w_q[rd_word(k_q)] <= eng_cm.rdata;
						k_q <= k_q + 3'h1;
						st_q <= (k_q == RD_LAST) ? S_DEC : S_RD;
					end
				end
				S_DEC: begin
					idle_q <= 1'b0;
					pos_q <= 6'h00;
					mid_q <= 1'b0;
					done_buf_q <= 1'b0;
					cell_done_q <= 1'b0;
					k_q <= 3'h0;
					if (!w_q[TX_DMA_GROUP_ENABLE][BIT_GROUP_ENABLE]) begin
						idle_q <= 1'b1;
						st_q <= S_CELL;
					end else if (!state_w[BIT_OWN]) begin
						st_q <= S_DREQ;
					end else begin
						st_q <= S_CELL;
					end
				end
				S_DREQ: begin
					hm_req_q <= 1'b1;
					hm_we_q <= 1'b0;
					hm_addr_q <= ring_w + {28'h0, k_q[1:0], 2'b00};
					st_q <= S_DWAIT;
				end
				S_DWAIT: begin
					if (hm_rvalid) begin
						dsc_q[k_q[1:0]] <= hm_rdata;
						k_q <= k_q + 3'h1;
						st_q <= (k_q == DESC_LAST) ? S_DLOAD : S_DREQ;
					end
				end
				S_DLOAD: begin
					if (!dsc_q[0][BIT_OWN]) begin
						if (mid_q) begin
							w_q[TX_DMA_STATE_WORD][BIT_LAST_BUF] <= 1'b1;
							st_q <= ret_st;
						end else begin
							idle_q <= 1'b1;
							st_q <= S_CELL;
						end
					end else begin
						prev_desc_q <= ring_w;
						w_q[TX_DMA_RING_POINTER][11:4] <= ring_w[11:4] + 8'h01;
						w_q[TX_DMA_STATE_WORD] <= {1'b1, dsc_q[0][30:27],
							dsc_q[0][BIT_FIRST_BUF] ? dsc_q[0][26:16] : state_w[26:16],
							dsc_q[0][15:0]};
						w_q[TX_DMA_CURRENT_POINTER] <= dsc_q[1];
						if (dsc_q[0][BIT_FIRST_BUF]) begin
							w_q[TX_DMA_CELL_HEADER] <= dsc_q[2];
							w_q[TX_DMA_TRAILER_FIELDS] <= dsc_q[3];
							w_q[TX_DMA_PARTIAL_CRC] <= CRC_INIT;
						end
						st_q <= mid_q ? ret_st : S_CELL;
					end
				end
				S_CELL: begin
					sop_q <= (pos_q == 6'h00);
					if (pos_q < HDR_BYTES) begin
						byte_q <= hdr_word[{~pos_q[1:0], 3'b111} -: 8];
						st_q <= S_EMIT;
					end else if (idle_q) begin
						byte_q <= 8'h00;
						st_q <= S_EMIT;
					end else if (state_w[15:0] != 16'h0000) begin
						hm_req_q <= 1'b1;
						hm_we_q <= 1'b0;
						hm_addr_q <= {ptr_w[31:2], 2'b00};
						st_q <= S_FWAIT;
					end else begin
						byte_q <= pad_byte;
						if (pad_in_crc)
							w_q[TX_DMA_PARTIAL_CRC] <= crc_byte(crc_w, pad_byte);
						st_q <= S_EMIT;
					end
				end
				S_FWAIT: begin
					if (hm_rvalid) begin
						byte_q <= lane_byte;
						w_q[TX_DMA_CURRENT_POINTER] <= ptr_w + 32'h00000001;
						w_q[TX_DMA_STATE_WORD][15:0] <= state_w[15:0] + 16'h0001;
						done_buf_q <= (state_w[15:0] == BUF_LAST_BYTE);
						if (aal5)
							w_q[TX_DMA_PARTIAL_CRC] <= crc_byte(crc_w, lane_byte);
						st_q <= S_EMIT;
					end
				end
				S_EMIT: begin
					if (buf_rdy) begin
						cell_done_q <= (pos_q == CELL_LAST_POS);
						pos_q <= (pos_q == CELL_LAST_POS) ? 6'h00 : pos_q + 6'h01;
						if (done_buf_q)
							st_q <= S_OCLR;
						else if (pos_q == CELL_LAST_POS)
							st_q <= S_END;
						else
							st_q <= S_CELL;
					end
				end
				S_OCLR: begin
					hm_req_q <= 1'b1;
					hm_we_q <= 1'b1;
					hm_addr_q <= prev_desc_q;
					hm_wdata_q <= {1'b0, dsc_q[0][30:0]};
					st_q <= S_OWAIT;
				end
				S_OWAIT: begin
					if (hm_req_q && hm_gnt) begin
						done_buf_q <= 1'b0;
						w_q[TX_DMA_STATE_WORD][BIT_FIRST_BUF] <= 1'b0;
						if (!state_w[BIT_LAST_BUF]) begin
							mid_q <= 1'b1;
							k_q <= 3'h0;
							st_q <= S_DREQ;
						end else begin
							st_q <= ret_st;
						end
					end
				end
				S_END: begin
					k_q <= 3'h0;
					if (idle_q) begin
						st_q <= S_WAIT;
					end else begin
						w_q[TX_DMA_STATE_WORD][26:16] <= state_w[26:16] + 11'h001;
						if (last_cell) begin
							cmpl_v_q <= 1'b1;
							cmpl_grp_q <= grp_q;
							cmpl_irq_q <= !state_w[BIT_COMPLETION_IRQ_SUPPRESS];
							w_q[TX_DMA_STATE_WORD][BIT_OWN] <= 1'b0;
						end
						st_q <= S_WB;
					end
				end
				S_WB: begin
					ecm_req_q <= 1'b1;
					ecm_we_q <= 1'b1;
					ecm_word_q <= wb_word(k_q);
					ecm_wdata_q <= w_q[wb_word(k_q)];
					k_q <= k_q + 3'h1;
					if (k_q == WB_LAST)
						st_q <= S_WAIT;
				end
			endcase
		end
	end
	// Two-entry output buffer
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			out_q <= 10'h000;
			out_v_q <= 1'b0;
			skid_q <= 10'h000;
			skid_v_q <= 1'b0;
		end else if (cell_ready || !out_v_q) begin
			if (skid_v_q) begin
				out_q <= skid_q;
				out_v_q <= 1'b1;
				skid_v_q <= 1'b0;
			end else begin
				out_q <= {idle_q, sop_q, byte_q};
				out_v_q <= push;
			end
		end else if (push) begin
			skid_q <= {idle_q, sop_q, byte_q};
			skid_v_q <= 1'b1;
		end
	end
	assign opp_ready = opp_rdy_q;
	assign hm_req = hm_req_q;
	assign hm_we = hm_we_q;
	assign hm_addr = hm_addr_q;
	assign hm_wdata = hm_wdata_q;
	assign cell_valid = out_v_q;
	assign cell_idle = out_q[9];
	assign cell_sop = out_q[8];
	assign cell_data = out_q[7:0];
	assign cmpl_valid = cmpl_v_q;
	assign cmpl_group = cmpl_grp_q;
	assign cmpl_irq = cmpl_irq_q;
endmodule
`default_nettype wire

// File: hw/atx_pkg.sv
// Constants, types and helpers for the transmit segmentation DMA.
// Assumes one core clock and an active-low asynchronous reset.
`default_nettype none
package atx_pkg;
	localparam int unsigned ATX_GROUPS = 255;
	localparam int unsigned ATX_WORDS = 8;
	localparam int unsigned ATX_CM_AW = 11;
	localparam logic [2:0] TX_DMA_STATE_WORD = 3'h0;
	localparam logic [2:0] TX_DMA_CURRENT_POINTER = 3'h1;
	localparam logic [2:0] TX_DMA_CELL_HEADER = 3'h2;
	localparam logic [2:0] TX_DMA_GROUP_ENABLE = 3'h3;
	localparam logic [2:0] TX_DMA_RING_POINTER = 3'h4;
	localparam logic [2:0] TX_DMA_RESERVED = 3'h5;
	localparam logic [2:0] TX_DMA_PARTIAL_CRC = 3'h6;
	localparam logic [2:0] TX_DMA_TRAILER_FIELDS = 3'h7;
	localparam int unsigned BIT_OWN = 31;
	localparam int unsigned BIT_FIRST_BUF = 30;
	localparam int unsigned BIT_LAST_BUF = 29;
	localparam int unsigned BIT_COMPLETION_IRQ_SUPPRESS = 28;
	localparam int unsigned BIT_ADAPTATION_TYPE = 27;
	localparam int unsigned BIT_GROUP_ENABLE = 31;
	localparam logic [10:0] PKT_LAST_CELL = 11'h7ff;
	localparam logic [15:0] BUF_LAST_BYTE = 16'hffff;
	localparam logic [31:0] CRC_INIT = 32'hffffffff;
	localparam logic [31:0] CRC_POLY = 32'h04c11db7;
	localparam logic [31:0] IDLE_HEADER = 32'h00000001;
	localparam logic [31:0] WORD_RESET = 32'h00000000;
	localparam logic [5:0] HDR_BYTES = 6'h04;
	localparam logic [5:0] TAIL_POS = 6'h2c;
	localparam logic [5:0] CRC_POS = 6'h30;
	localparam logic [5:0] CELL_LAST_POS = 6'h33;
	localparam logic [2:0] RD_LAST = 3'h6;
	localparam logic [2:0] WB_LAST = 3'h5;
	localparam logic [2:0] DESC_LAST = 3'h3;
	typedef enum logic [3:0] {
		S_WAIT, S_RD, S_RDW, S_DEC, S_DREQ, S_DWAIT, S_DLOAD, S_CELL,
		S_FWAIT, S_EMIT, S_OCLR, S_OWAIT, S_END, S_WB
	} atx_state_t;

	function automatic logic [2:0] rd_word(input logic [2:0] k);
		unique case (k)
			3'h0: return TX_DMA_GROUP_ENABLE;
			3'h1: return TX_DMA_STATE_WORD;
			3'h2: return TX_DMA_RING_POINTER;
			3'h3: return TX_DMA_CURRENT_POINTER;
			3'h4: return TX_DMA_CELL_HEADER;
			3'h5: return TX_DMA_PARTIAL_CRC;
			default: return TX_DMA_TRAILER_FIELDS;
		endcase
	endfunction

	function automatic logic [2:0] wb_word(input logic [2:0] k);
		unique case (k)
			3'h0: return TX_DMA_STATE_WORD;
			3'h1: return TX_DMA_CURRENT_POINTER;
			3'h2: return TX_DMA_CELL_HEADER;
			3'h3: return TX_DMA_RING_POINTER;
			3'h4: return TX_DMA_PARTIAL_CRC;
			default: return TX_DMA_TRAILER_FIELDS;
		endcase
	endfunction

	function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
		logic [31:0] r;
		r = c;
		for (int i = 7; i >= 0; i--) begin
			r = (r[31] ^ b[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
		end
		return r;
	endfunction
endpackage
`default_nettype wire

// File: hw/atx_cm_if.sv
// Word port into the control memory, one per user.
// Assumes read data arrive one clock after the request.
`default_nettype none
interface atx_cm_if #(
	parameter int unsigned AW = 11
);
	logic          req;
	logic          we;
	logic [AW-1:0] addr;
	logic [31:0]   wdata;
	logic [31:0]   rdata;
	logic          rvalid;
	modport user (output req, output we, output addr, output wdata, input rdata, input rvalid);
	modport mem (input req, input we, input addr, input wdata, output rdata, output rvalid);
endinterface
`default_nettype wire

// File: hw/atx_cmem.sv
// Two-port control memory holding the per-group DMA entries.
// Assumes both ports on core_clk; port b wins a same-word write.
`default_nettype none
module atx_cmem #(
	parameter int unsigned AW    = 11,
	parameter int unsigned DEPTH = 2040
) (
	input  wire logic core_clk,
	input  wire logic rst_b,
	atx_cm_if.mem     a,
	atx_cm_if.mem     b
);
	localparam logic [AW:0] LIM = (AW + 1)'(DEPTH);
	logic [31:0] mem_q [DEPTH];
	logic [31:0] a_rd_q;
	logic [31:0] b_rd_q;
	logic        a_v_q;
	logic        b_v_q;
	if (DEPTH > (1 << AW)) begin : g_chk
		$error("Control memory depth exceeds address range");
	end
	always_ff @(posedge core_clk) begin
		if (a.req && a.we && ({1'b0, a.addr} < LIM))
			mem_q[a.addr] <= a.wdata;
		if (b.req && b.we && ({1'b0, b.addr} < LIM))
			mem_q[b.addr] <= b.wdata;
		a_rd_q <= ({1'b0, a.addr} < LIM) ? mem_q[a.addr] : 32'h00000000;
		b_rd_q <= ({1'b0, b.addr} < LIM) ? mem_q[b.addr] : 32'h00000000;
	end
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			a_v_q <= 1'b0;
			b_v_q <= 1'b0;
		end else begin
			a_v_q <= a.req && !a.we;
			b_v_q <= b.req && !b.we;
		end
	end
	assign a.rdata = a_rd_q;
	assign a.rvalid = a_v_q;
	assign b.rdata = b_rd_q;
	assign b.rvalid = b_v_q;
endmodule
`default_nettype wire

// File: sim/atx_tx_dma_properties.sv
// Property checker on the transmit segmentation DMA ports.
// Assumes it is bound onto atx_tx_dma; one clock, reset rst_b.
`default_nettype none
module atx_tx_dma_properties #(
	parameter int unsigned CM_AW = 11
) (
	input wire logic		core_clk,
	input wire logic		rst_b,
	input wire logic		opp_valid,
	input wire logic		opp_ready,
	input wire logic		cm_req,
	input wire logic		cm_we,
	input wire logic [CM_AW-1:0]	cm_addr,
	input wire logic		cm_rvalid,
	input wire logic [31:0]	cm_rdata,
	input wire logic		hm_req,
	input wire logic		hm_gnt,
	input wire logic [31:0]	hm_addr,
	input wire logic		cell_valid,
	input wire logic		cell_ready,
	input wire logic [7:0]	cell_data,
	input wire logic		cell_sop,
	input wire logic		cmpl_valid,
	input wire logic		cmpl_irq
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam int CM_TOP = 2040;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	cm_read_answer_a: assert property (cm_req && !cm_we |=> cm_rvalid)
		else $error("control read not answered");
	cm_unmapped_a: assert property (cm_req && !cm_we && cm_addr >= CM_TOP |=> cm_rdata == 32'h0)
		else $error("unmapped read not zero");
	hm_req_hold_a: assert property (hm_req && !hm_gnt |=> hm_req && $stable(hm_addr))
		else $error("host request dropped");
	hm_word_addr_a: assert property (hm_req |-> hm_addr[1:0] == 2'h0)
		else $error("host address not word aligned");
	cell_hold_a: assert property (cell_valid && !cell_ready |=>
		cell_valid && $stable(cell_data) && $stable(cell_sop))
		else $error("cell byte lost in stall");
	gfc_zero_a: assert property (cell_valid && cell_sop |-> cell_data[7:4] == 4'h0)
		else $error("top header bits not zero");
	irq_cmpl_a: assert property (cmpl_irq |-> cmpl_valid)
		else $error("interrupt without completion");
	cmpl_pulse_a: assert property (cmpl_valid |=> !cmpl_valid)
		else $error("completion longer than a cycle");
	opp_take_a: assert property (opp_valid && opp_ready |=> !opp_ready)
		else $error("opportunity not held");
endmodule
bind atx_tx_dma atx_tx_dma_properties #(.CM_AW(CM_AW)) props (
	.core_clk, .rst_b, .opp_valid, .opp_ready, .cm_req, .cm_we, .cm_addr, .cm_rvalid,
	.cm_rdata, .hm_req, .hm_gnt, .hm_addr, .cell_valid, .cell_ready, .cell_data, .cell_sop,
	.cmpl_valid, .cmpl_irq
);
`default_nettype wire

// File: sim/atx_host_mem.sv
// Host memory model: word store behind the engine's master port.
// Assumes the bench preloads mem; slow sets grant and read delay.
`default_nettype none
module atx_host_mem (
	input wire logic		core_clk,
	input wire logic		rst_b,
	input wire logic [1:0]	slow,
	input wire logic		hm_req,
	input wire logic		hm_we,
	input wire logic [31:0]	hm_addr,
	input wire logic [31:0]	hm_wdata,
	output logic			hm_gnt,
	output logic			hm_rvalid,
	output logic [31:0]		hm_rdata
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [31:0]	mem [4096];
	logic [11:0]	idx_q;
	logic [1:0]	wait_q;
	logic		pend_q;

	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			{hm_gnt, hm_rvalid, pend_q, wait_q, idx_q} <= '0;
			hm_rdata <= 32'h0;
		end else begin
			hm_gnt <= 1'b0;
			hm_rvalid <= 1'b0;
			// Idle data toggles so a stale word never passes as an answer
			hm_rdata <= ~hm_rdata;
			if (hm_req && hm_gnt) begin
				if (hm_we) mem[hm_addr[13:2]] <= hm_wdata;
				pend_q <= !hm_we;
				idx_q <= hm_addr[13:2];
				wait_q <= slow;
			end else if (wait_q != 2'h0) begin
				wait_q <= wait_q - 2'h1;
			end else if (pend_q) begin
				hm_rvalid <= 1'b1;
				hm_rdata <= mem[idx_q];
				pend_q <= 1'b0;
				wait_q <= slow;
			end else if (hm_req) begin
				hm_gnt <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// File: sim/atx_tx_dma_bench.sv
// Self-checking bench for the transmit segmentation DMA.
// Assumes the host memory model and the bound property checker.
`default_nettype none
module atx_tx_dma_bench
	import atx_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic		core_clk, rst_b, opp_valid, opp_ready, cm_req, cm_we, cm_rvalid;
	logic		hm_req, hm_we, hm_gnt, hm_rvalid, cell_valid, cell_ready;
	logic		cell_sop, cell_idle, cmpl_valid, cmpl_irq, cmpl_irq_s;
	logic [1:0]	slow;
	logic [7:0]	opp_group, cell_data, cmpl_group, cmpl_grp_s;
	logic [10:0]	cm_addr;
	logic [31:0]	cm_wdata, cm_rdata, hm_addr, hm_wdata, hm_rdata, q;
	int		fails, num_checks, cmpl_n;

	atx_tx_dma dut (
		.core_clk, .rst_b, .opp_valid, .opp_ready, .opp_group, .cm_req, .cm_we, .cm_addr,
		.cm_wdata, .cm_rvalid, .cm_rdata, .hm_req, .hm_we, .hm_addr, .hm_wdata, .hm_gnt,
		.hm_rvalid, .hm_rdata, .cell_valid, .cell_ready, .cell_data, .cell_sop, .cell_idle,
		.cmpl_valid, .cmpl_group, .cmpl_irq
	);
	atx_host_mem hm (
		.core_clk, .rst_b, .slow, .hm_req, .hm_we, .hm_addr, .hm_wdata, .hm_gnt,
		.hm_rvalid, .hm_rdata
	);

	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		if (cmpl_valid) begin
			cmpl_n++;
			cmpl_irq_s = cmpl_irq;
			cmpl_grp_s = cmpl_group;
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	function automatic logic [7:0] hb(input logic [31:0] a);
		return a[7:0] ^ {a[11:8], 4'h5};
	endfunction

	function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] b);
		c = c ^ {b, 24'h0};
		for (int i = 0; i < 8; i++) c = c[31] ? {c[30:0], 1'b0} ^ 32'h04c11db7 : {c[30:0], 1'b0};
		return c;
	endfunction

	task automatic cm(input logic we, input logic [7:0] g, input logic [2:0] w,
		input logic [31:0] d, output logic [31:0] rd);
		cm_req = 1'b1;
		cm_we = we;
		cm_addr = {g, w};
		cm_wdata = d;
		@(posedge core_clk);
		#1;
		cm_req = 1'b0;
		rd = cm_rdata;
		if (!we) check(cm_rvalid, 1'b1);
		@(posedge core_clk);
		#1;
	endtask

	task automatic grp_init(input logic [7:0] g, input logic [31:0] en, input logic [31:0] ring);
		cm(1'b1, g, TX_DMA_GROUP_ENABLE, en, q);
		cm(1'b1, g, TX_DMA_STATE_WORD, 32'h0, q);
		cm(1'b1, g, TX_DMA_RING_POINTER, ring, q);
	endtask

	task automatic wait_ready();
		for (int t = 0; t < 3000 && opp_ready !== 1'b1; t++) begin
			@(posedge core_clk);
			#1;
		end
		check(opp_ready, 1'b1);
	endtask

	task automatic get_cell(input logic [7:0] g, output logic [7:0] cb [52], output logic idl);
		int i;
		i = 0;
		wait_ready();
		opp_valid = 1'b1;
		opp_group = g;
		@(posedge core_clk);
		#1;
		opp_valid = 1'b0;
		for (int t = 0; t < 4000 && i < 52; t++) begin
			if (cell_valid && cell_ready) begin
				cb[i] = cell_data;
				check(cell_sop, i == 0);
				if (i == 0) idl = cell_idle;
				i++;
			end
			@(posedge core_clk);
			#1;
			cell_ready = (t % 3) != 2;
		end
		check(i, 52);
	endtask

	task automatic idle_chk(input logic [7:0] g);
		logic [7:0]	cb [52];
		logic		idl;
		get_cell(g, cb, idl);
		check(idl, 1'b1);
		check({cb[0], cb[1], cb[2], cb[3]}, IDLE_HEADER);
		for (int k = 4; k < 52; k++) check(cb[k], 8'h00);
		wait_ready();
		cm(1'b0, g, TX_DMA_RING_POINTER, 32'h0, q);
		check(q, 32'h1000);
	endtask

	task automatic run_pkt(input logic [7:0] g, input logic [31:0] ring, input logic [31:0] d [4],
		input int n, input int cells, input logic irq);
		logic [7:0]	exp [$];
		logic [7:0]	cb [52];
		logic		idl;
		logic [31:0]	crc;
		logic [3:0]	nib;
		crc = 32'hffffffff;
		for (int i = 0; i < 4; i++) hm.mem[ring[13:2] + i] = d[i];
		grp_init(g, 32'h80000000, ring);
		for (int k = 0; k < cells * 48; k++) exp.push_back(k < n ? hb(d[1] + k) : 8'h00);
		if (!d[0][BIT_ADAPTATION_TYPE]) begin
			for (int j = 0; j < 4; j++) exp[cells*48-8+j] = d[3][8*(3-j)+:8];
			for (int k = 0; k < cells * 48 - 4; k++) crc = crc_step(crc, exp[k]);
			for (int j = 0; j < 4; j++) exp[cells*48-4+j] = ~crc[8*(3-j)+:8];
		end
		cmpl_n = 0;
		for (int c = 0; c < cells; c++) begin
			get_cell(g, cb, idl);
			nib = (c == cells - 1) ? d[2][31:28] : d[2][3:0];
			check({cb[0], cb[1], cb[2], cb[3]}, {4'h0, d[2][27:4], nib});
			for (int k = 0; k < 48; k++) check(cb[4+k], exp[c*48+k]);
			check(idl, 1'b0);
		end
		// The holding register frees early; let completion and write-back finish
		repeat (12) @(posedge core_clk);
		#1;
		wait_ready();
		check(cmpl_n, 1);
		check({cmpl_irq_s, cmpl_grp_s}, {irq, g});
		cm(1'b0, g, TX_DMA_STATE_WORD, 32'h0, q);
		check(q, {2'h0, d[0][29:27], 27'h0});
		cm(1'b0, g, TX_DMA_CURRENT_POINTER, 32'h0, q);
		check(q, d[1] + n);
		cm(1'b0, g, TX_DMA_RING_POINTER, 32'h0, q);
		check(q, ring + 32'h10);
		check(hm.mem[ring[13:2]], {1'b0, d[0][30:0]});
	endtask

	task automatic results();
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// Watchdog: the whole sequence needs well under 10000 cycles
	initial begin
		#100000;
		fails++;
		results();
	end

	initial begin
		{rst_b, opp_valid, cm_req, cm_we} = 4'h0;
		{opp_group, cm_addr, cm_wdata, slow} = '0;
		cell_ready = 1'b1;
		{fails, num_checks, cmpl_n} = '0;
		for (int i = 0; i < 4096; i++) hm.mem[i] = {hb(4*i+3), hb(4*i+2), hb(4*i+1), hb(4*i)};
		repeat (20) @(posedge core_clk);
		#1;
		check({opp_ready, cell_valid, hm_req, cmpl_valid, cmpl_irq}, 5'h10);
		rst_b = 1'b1;
		@(posedge core_clk);
		#1;
		for (int w = 0; w < 8; w++) begin
			cm(1'b1, 8'h05, w[2:0], 32'h5a000000 | w, q);
			cm(1'b0, 8'h05, w[2:0], 32'h0, q);
			if (w != 5) check(q, 32'h5a000000 | w);
		end
		cm(1'b1, 8'hff, 3'h1, 32'hffffffff, q);
		cm(1'b0, 8'hff, 3'h1, 32'h0, q);
		check(q, 32'h0);
		$display("test registers done");
		grp_init(8'h00, 32'h0, 32'h1000);
		idle_chk(8'h00);
		$display("test disabled group done");
		hm.mem[12'h400] = 32'h0;
		grp_init(8'h01, 32'h80000000, 32'h1000);
		idle_chk(8'h01);
		$display("test unowned descriptor done");
		slow = 2'h2;
		run_pkt(8'h02, 32'h1100, '{32'he7feffce, 32'h2003, 32'h31234560, 32'h12340032}, 50, 2, 1'b1);
		$display("test aal5 packet done");
		slow = 2'h0;
		run_pkt(8'h03, 32'h1200, '{32'hffffffd0, 32'h2100, 32'h2abcdef2, 32'h0}, 48, 1, 1'b0);
		$display("test null packet done");
		results();
	end
endmodule
`default_nettype wire
